/* design/ring_detect_and_cid_control.sv */
// ring detection, ringing monitor and caller id routing with its register bank
// assumes sense samples arrive from the auxiliary converter as one-cycle strobes
// and that the pcm serialiser drains the output fifo with valid/ready
//
// Contract
// - caller id mode routes ring sense to pcm
// - caller id path gets fixed 20 dB boost
// - receive boost bit adds 20 dB gain
// - ring irq enable gates interrupt, resets set
// - ring flag latches over threshold, clears on read
// - ring flag masked only by irq enable
// - ringing monitor follows activity, cleared by read
// - threshold code selects level, zero disables
// - detection compares against programmed threshold field
`timescale 1ns/1ps

// synchronous fifo, one word per accepted handshake
module sample_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rstn,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
  localparam logic [AW-1:0] LAST_SLOT  = AW'(DEPTH - 1);

  // whole fifo state in one record
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;   // storage
    logic [AW-1:0]               wptr;  // next write slot
    logic [AW-1:0]               rptr;  // oldest word
    logic [CW-1:0]               count; // words held
  } fifo_state_t;

  fifo_state_t s_q;  // registered state
  fifo_state_t s_d;  // next state
  logic        push; // word accepted
  logic        pop;  // word delivered

  // handshakes; full and empty come straight from the count
  assign in_ready  = (s_q.count != FULL_COUNT);
  assign out_valid = (s_q.count != '0);
  assign out_data  = s_q.mem[s_q.rptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // pointer wrap, written for depths that are not powers of two
  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == LAST_SLOT) ? '0 : AW'(p + 1'b1);
  endfunction : bump

  // next state
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wptr] = in_data;
      s_d.wptr          = bump(s_q.wptr);
    end
    if (pop) begin
      s_d.rptr = bump(s_q.rptr);
    end
    // simultaneous push and pop leave the count alone
    if (push && !pop) begin
      s_d.count = CW'(s_q.count + 1'b1);
    end else if (pop && !push) begin
      s_d.count = CW'(s_q.count - 1'b1);
    end
  end

  // state register
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : sample_fifo

// control block
module ring_detect_and_cid_control (
  // clock and reset
  input  wire logic                   mclk,
  input  wire logic                   rstn,
  // register port
  input  wire ring_cid_pkg::reg_req_t reg_req,
  output logic [7:0]                  reg_rdata,
  output logic                        reg_rvalid,
  // auxiliary converter ring sense samples, ones complement
  input  wire logic [7:0]             ring_sense_sample,
  input  wire logic                   ring_sense_valid,
  output logic                        ring_sense_ready,
  // normal receive path samples, 16-bit linear
  input  wire logic [15:0]            rx_sample,
  input  wire logic                   rx_valid,
  output logic                        rx_ready,
  // pcm transmit output
  output logic [15:0]                 pcm_send_line,
  output logic                        pcm_valid,
  input  wire logic                   pcm_ready,
  // interrupt and mode status
  output logic                        ring_irq,
  output logic                        cid_active
);
  ring_cid_pkg::ctrl_state_t s_q;     // registered state
  ring_cid_pkg::ctrl_state_t s_d;     // next state
  logic                      detect;  // sample above threshold
  logic                      st_read; // status register read
  logic [15:0]               sense_lin; // ring sense as linear pcm
  logic [15:0]               src_word;  // selected source word
  logic [15:0]               fifo_word; // word after receive boost
  logic                      fifo_in_valid;
  logic                      fifo_in_ready;

  // magnitude of a ones complement sample
  function automatic logic [6:0] sense_mag(input logic [7:0] x);
    sense_mag = x[7] ? ~x[6:0] : x[6:0];
  endfunction : sense_mag

  // code to exceed for a threshold setting
  function automatic logic [6:0] thr_code(input logic [1:0] sel);
    case (sel)
      2'h1:    thr_code = ring_cid_pkg::THR1_CODE;
      2'h2:    thr_code = ring_cid_pkg::THR2_CODE;
      default: thr_code = ring_cid_pkg::THR3_CODE;
    endcase
  endfunction : thr_code

  // fixed 20 dB boost with saturation; clipping beats wrap-around on loud rings
  function automatic logic [15:0] boost(input logic [15:0] x);
    logic signed [20:0] p;
    p = 21'($signed(x)) * ring_cid_pkg::BOOST_FACTOR;
    if (p > ring_cid_pkg::SAT_HI) begin
      boost = 16'h7FFF;
    end else if (p < ring_cid_pkg::SAT_LO) begin
      boost = 16'h8000;
    end else begin
      boost = p[15:0];
    end
  endfunction : boost

  // threshold compare; code zero turns detection off
  assign detect = ring_sense_valid && (s_q.ring_threshold_select != 2'h0) &&
                  (sense_mag(ring_sense_sample) >
                   thr_code(s_q.ring_threshold_select));
  assign st_read = reg_req.rd && (reg_req.addr == ring_cid_pkg::DETECTION_STATUS_ADDR);

  // ring sense scaled into the linear pcm range, sign restored
  assign sense_lin = ring_sense_sample[7] ?
                     16'(-({9'h000, sense_mag(ring_sense_sample)}
                           << ring_cid_pkg::SENSE_LIN_SHIFT)) :
                     16'({9'h000, sense_mag(ring_sense_sample)}
                         << ring_cid_pkg::SENSE_LIN_SHIFT);

  // source select: caller id replaces the receive path entirely
  assign src_word  = s_q.caller_id_route_enable ? boost(sense_lin)
                                                : rx_sample;
  assign fifo_word = s_q.receive_gain_boost ? boost(src_word) : src_word;
  assign fifo_in_valid = s_q.caller_id_route_enable ? ring_sense_valid : rx_valid;
  // disconnected receive path is drained and dropped so its source never hangs
  assign rx_ready         = s_q.caller_id_route_enable ? 1'b1 : fifo_in_ready;
  // the converter cannot stall; in caller id mode a full fifo shows here and the sample is lost, otherwise ready stays high
  assign ring_sense_ready = s_q.caller_id_route_enable ? fifo_in_ready : 1'b1;

  // next state: reads, clear-on-read, detection, writes
  always_comb begin
    s_d        = s_q;
    s_d.rvalid = 1'b0;
    // read decode
    if (reg_req.rd) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = 8'h00;
      if (reg_req.addr == ring_cid_pkg::DETECTION_STATUS_ADDR) begin
        s_d.rdata[ring_cid_pkg::RING_EVENT_FLAG_BIT]      = s_q.ring_event_flag;
        s_d.rdata[ring_cid_pkg::RINGING_LIVE_MONITOR_BIT] = s_q.ringing_live_monitor;
      end else if (reg_req.addr == ring_cid_pkg::INTERRUPT_ENABLE_ADDR) begin
        s_d.rdata[ring_cid_pkg::RING_IRQ_ENABLE_BIT] = s_q.ring_irq_enable;
      end else if (reg_req.addr == ring_cid_pkg::RING_THRESHOLD_CONTROL_ADDR) begin
        s_d.rdata[ring_cid_pkg::RING_THRESHOLD_SELECT_LSB +: 2] = s_q.ring_threshold_select;
      end else if (reg_req.addr == ring_cid_pkg::CALLER_ID_CONTROL_ADDR) begin
        s_d.rdata[ring_cid_pkg::CALLER_ID_ROUTE_ENABLE_BIT] = s_q.caller_id_route_enable;
      end
      // boost register is write-only and unmapped addresses read zero
    end
    // status read clears both bits
    if (st_read) begin
      s_d.ring_event_flag      = 1'b0;
      s_d.ringing_live_monitor = 1'b0;
    end
    // monitor tracks each new sample; a new event beats a same-cycle read
    if (ring_sense_valid) begin
      s_d.ringing_live_monitor = detect;
    end
    if (detect) begin
      s_d.ring_event_flag = 1'b1;
    end
    // write decode
    if (reg_req.wr) begin
      if (reg_req.addr == ring_cid_pkg::INTERRUPT_ENABLE_ADDR) begin
        s_d.ring_irq_enable = reg_req.wdata[ring_cid_pkg::RING_IRQ_ENABLE_BIT];
      end else if (reg_req.addr == ring_cid_pkg::RING_THRESHOLD_CONTROL_ADDR) begin
        s_d.ring_threshold_select =
          reg_req.wdata[ring_cid_pkg::RING_THRESHOLD_SELECT_LSB +: 2];
      end else if (reg_req.addr == ring_cid_pkg::RECEIVE_BOOST_CONTROL_ADDR) begin
        s_d.receive_gain_boost = reg_req.wdata[ring_cid_pkg::RECEIVE_GAIN_BOOST_BIT];
      end else if (reg_req.addr == ring_cid_pkg::CALLER_ID_CONTROL_ADDR) begin
        s_d.caller_id_route_enable =
          reg_req.wdata[ring_cid_pkg::CALLER_ID_ROUTE_ENABLE_BIT];
      end
    end
  end

  // state register with documented reset values
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_q                        <= '0;
      s_q.ring_irq_enable        <= ring_cid_pkg::RING_IRQ_ENABLE_RST;
      s_q.ring_threshold_select  <= ring_cid_pkg::THRESHOLD_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs
  assign reg_rdata  = s_q.rdata;
  assign reg_rvalid = s_q.rvalid;
  assign ring_irq   = s_q.ring_event_flag && s_q.ring_irq_enable;
  assign cid_active = s_q.caller_id_route_enable;

  // eight-word buffer ahead of the pcm serialiser
  sample_fifo #(
    .WIDTH (ring_cid_pkg::PCM_WIDTH),
    .DEPTH (ring_cid_pkg::FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rstn      (rstn),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_word),
    .out_valid (pcm_valid),
    .out_ready (pcm_ready),
    .out_data  (pcm_send_line)
  );

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  flag_sets_a: assert property (detect |=> s_q.ring_event_flag)
    else $error("ring flag missed an over-threshold sample");
  flag_clears_a: assert property (st_read && !detect |=> !s_q.ring_event_flag)
    else $error("ring flag survived a status read");
  thr_off_a: assert property (
    (s_q.ring_threshold_select == 2'h0) && !s_q.ring_event_flag && !reg_req.wr
    |=> !s_q.ring_event_flag)
    else $error("ring flag set with detection disabled");
  irq_masked_a: assert property (!s_q.ring_irq_enable |-> !ring_irq)
    else $error("interrupt raised while masked");
  irq_rise_a: assert property (
    detect && s_q.ring_irq_enable && !reg_req.wr |=> ring_irq)
    else $error("interrupt missing after enabled ring event");
  irq_drop_a: assert property (st_read && !detect ##1 1 |-> !ring_irq)
    else $error("interrupt held after flag read");
  live_follow_a: assert property (
    ring_sense_valid |=> s_q.ringing_live_monitor == $past(detect))
    else $error("ringing monitor not following sample");
  monitor_read_a: assert property (
    st_read && !ring_sense_valid |=> !s_q.ringing_live_monitor)
    else $error("ringing monitor survived a status read");
  thr_write_a: assert property (
    reg_req.wr && (reg_req.addr == ring_cid_pkg::RING_THRESHOLD_CONTROL_ADDR)
    |=> s_q.ring_threshold_select ==
        $past(reg_req.wdata[ring_cid_pkg::RING_THRESHOLD_SELECT_LSB +: 2]))
    else $error("threshold write not taken");
  cid_route_a: assert property (
    s_q.caller_id_route_enable && !s_q.receive_gain_boost
    |-> fifo_word == boost(sense_lin) && rx_ready)
    else $error("caller id path not boosted ring sense");
  rx_boost_a: assert property (
    !s_q.caller_id_route_enable && s_q.receive_gain_boost
    |-> fifo_word == boost(rx_sample) && fifo_in_valid == rx_valid)
    else $error("receive boost not applied");
  receive_gain_boost_write_a: assert property (
    reg_req.wr && (reg_req.addr == ring_cid_pkg::RECEIVE_BOOST_CONTROL_ADDR)
    |=> s_q.receive_gain_boost ==
        $past(reg_req.wdata[ring_cid_pkg::RECEIVE_GAIN_BOOST_BIT]))
    else $error("receive boost write not taken");
  cid_write_a: assert property (
    reg_req.wr && (reg_req.addr == ring_cid_pkg::CALLER_ID_CONTROL_ADDR)
    |=> cid_active == $past(reg_req.wdata[ring_cid_pkg::CALLER_ID_ROUTE_ENABLE_BIT]))
    else $error("caller id mode write not taken");

endmodule : ring_detect_and_cid_control

/* design/ring_cid_pkg.sv */
// constants, field positions and carriers for the ring detect / caller id block
// assumes one 100 MHz clock, register port strobes synchronous to it
package ring_cid_pkg;

  // clock
  localparam int unsigned MCLK_HZ = 100_000_000;

  // register offsets
  localparam logic [7:0] DETECTION_STATUS_ADDR       = 8'h03;
  localparam logic [7:0] INTERRUPT_ENABLE_ADDR       = 8'h05;
  localparam logic [7:0] RING_THRESHOLD_CONTROL_ADDR = 8'h0E;
  localparam logic [7:0] RECEIVE_BOOST_CONTROL_ADDR  = 8'h14;
  localparam logic [7:0] CALLER_ID_CONTROL_ADDR      = 8'h15;

  // field positions
  localparam int unsigned RING_EVENT_FLAG_BIT        = 0;
  localparam int unsigned RINGING_LIVE_MONITOR_BIT   = 3;
  localparam int unsigned RING_IRQ_ENABLE_BIT        = 0;
  localparam int unsigned RING_THRESHOLD_SELECT_LSB  = 0;
  localparam int unsigned RECEIVE_GAIN_BOOST_BIT     = 3;
  localparam int unsigned CALLER_ID_ROUTE_ENABLE_BIT = 4;

  // reset values
  localparam logic       RING_IRQ_ENABLE_RST = 1'h1;
  localparam logic [1:0] THRESHOLD_RST       = 2'h0;

  // threshold levels at the sense input, in millivolts peak
  localparam int unsigned THR1_MV = 150;
  localparam int unsigned THR2_MV = 300;
  localparam int unsigned THR3_MV = 450;
  // converter step, in microvolts (1.31 V over 128 codes)
  localparam int unsigned SENSE_LSB_UV = 10_230;

  // codes a magnitude must exceed; rounded up so a level never trips early
  localparam logic [6:0] THR1_CODE = 7'((THR1_MV * 1000 + SENSE_LSB_UV - 1) / SENSE_LSB_UV);
  localparam logic [6:0] THR2_CODE = 7'((THR2_MV * 1000 + SENSE_LSB_UV - 1) / SENSE_LSB_UV);
  localparam logic [6:0] THR3_CODE = 7'((THR3_MV * 1000 + SENSE_LSB_UV - 1) / SENSE_LSB_UV);

  // gain boost: 20 dB is a factor of ten in amplitude
  localparam int unsigned       BOOST_DB     = 20;
  localparam logic signed [20:0] BOOST_FACTOR = 21'sh0000A;
  localparam logic signed [20:0] SAT_HI       = 21'sh07FFF;
  localparam logic signed [20:0] SAT_LO       = -21'sh08000;

  // sample widths and buffering
  localparam int unsigned PCM_WIDTH  = 16;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned SENSE_LIN_SHIFT = 8;

  // register port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // complete state of the control block
  typedef struct packed {
    logic       ring_event_flag;
    logic       ringing_live_monitor;
    logic       ring_irq_enable;
    logic [1:0] ring_threshold_select;
    logic       receive_gain_boost;
    logic       caller_id_route_enable;
    logic [7:0] rdata;
    logic       rvalid;
  } ctrl_state_t;

endpackage : ring_cid_pkg

/* verification/pcm_drain_model.sv */
// pcm drain model: stands for the serialiser that empties the output fifo
// assumes the block's mclk and rstn; stall is commanded by the bench
`timescale 1ns/1ps
module pcm_drain_model (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // bench control
  input  wire logic        stall,
  // fifo draining side
  input  wire logic [15:0] pcm_send_line,
  input  wire logic        pcm_valid,
  output logic             pcm_ready
);
  logic [15:0] got [$];  // words taken, oldest first

  // ready moves only off the sampling edge, so no handshake race
  always @(negedge mclk) pcm_ready <= rstn && !stall;

  // take a word at each completed handshake
  always @(posedge mclk) begin
    if (rstn && pcm_valid && pcm_ready) got.push_back(pcm_send_line);
  end
endmodule : pcm_drain_model

/* verification/test_ring_detect_and_cid_control.sv */
// self-checking bench for the ring detect and caller id block
// assumes the strobe register port and a pcm drain model on the output side
`timescale 1ns/1ps
module test_ring_detect_and_cid_control;
  logic                   mclk;               // 100 MHz clock
  logic                   rstn;               // active low reset
  ring_cid_pkg::reg_req_t reg_req;            // register request
  logic [7:0]             reg_rdata;          // read data
  logic                   reg_rvalid;         // read answer strobe
  logic [7:0]             ring_sense_sample;  // converter sample
  logic                   ring_sense_valid;   // sample strobe
  logic                   ring_sense_ready;   // converter backpressure
  logic [15:0]            rx_sample;          // receive path word
  logic                   rx_valid;           // receive word present
  logic                   rx_ready;           // receive word accepted
  logic [15:0]            pcm_send_line;      // fifo head
  logic                   pcm_valid;          // fifo not empty
  logic                   pcm_ready;          // drain handshake
  logic                   ring_irq;           // interrupt request
  logic                   cid_active;         // caller id mode shown
  logic                   stall;              // holds the drain side off
  logic [7:0]             rd_val;             // last value read
  logic [6:0]             thr [4];            // trip codes per threshold select
  int                     miscompares;
  int                     cmp_count;
  int                     i;

  ring_detect_and_cid_control uut (.mclk, .rstn, .reg_req, .reg_rdata, .reg_rvalid,
    .ring_sense_sample, .ring_sense_valid, .ring_sense_ready, .rx_sample, .rx_valid,
    .rx_ready, .pcm_send_line, .pcm_valid, .pcm_ready, .ring_irq, .cid_active);
  pcm_drain_model sink (.mclk, .rstn, .stall, .pcm_send_line, .pcm_valid, .pcm_ready);

  // compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  // one write strobe, held across one rising edge
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge mclk);
    reg_req.wr = 1'b0;
  endtask : wr_reg

  // read strobe; the answer stands for the cycle after the taking edge
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge mclk);
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge mclk);
    reg_req.rd = 1'b0;
    check(16'(reg_rvalid), 16'h0001);
    rd_val = reg_rdata;
    check(16'(rd_val), 16'(exp));
  endtask : rd_chk

  // negative sense sample of magnitude m, ones complement
  task automatic sense(input logic [6:0] m);
    @(negedge mclk);
    ring_sense_sample = {1'b1, ~m};
    ring_sense_valid  = 1'b1;
    @(negedge mclk);
    ring_sense_valid  = 1'b0;
  endtask : sense

  // one receive word, offered while the fifo has room
  task automatic rx_put(input logic [15:0] w);
    @(negedge mclk);
    rx_sample = w;
    rx_valid  = 1'b1;
    @(negedge mclk);
    rx_valid  = 1'b0;
  endtask : rx_put

  // bounded wait for the next drained word
  task automatic expect_word(input logic [15:0] exp);
    for (int k = 0; k < 20 && sink.got.size() == 0; k++) @(negedge mclk);
    check(sink.got.size() > 0 ? sink.got.pop_front() : 16'hXXXX, exp);
  endtask : expect_word

  task automatic conclude();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  // free running clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    miscompares++;
    conclude();
  end

  // main sequence
  initial begin
    rstn = 1'b0;
    reg_req = '0;
    ring_sense_sample = 8'h00;
    ring_sense_valid = 1'b0;
    rx_sample = 16'h0000;
    rx_valid = 1'b0;
    stall = 1'b0;
    miscompares = 0;
    cmp_count = 0;
    thr = '{7'h00, ring_cid_pkg::THR1_CODE, ring_cid_pkg::THR2_CODE, ring_cid_pkg::THR3_CODE};
    repeat (10) @(negedge mclk);
    rstn = 1'b1;
    // reset values; the write-only boost register reads zero
    rd_chk(8'h05, 8'h01);
    rd_chk(8'h03, 8'h00);
    rd_chk(8'h0E, 8'h00);
    rd_chk(8'h15, 8'h00);
    rd_chk(8'h14, 8'h00);
    check(16'({ring_irq, cid_active}), 16'h0000);
    // detection off at select zero, even at full scale
    sense(7'h7F);
    rd_chk(8'h03, 8'h00);
    // each level: equal does not trip, one step above does
    for (i = 1; i < 4; i++) begin
      wr_reg(8'h0E, 8'(i));
      sense(thr[i]);
      rd_chk(8'h03, 8'h00);
      sense(thr[i] + 7'h01);
      @(negedge mclk);
      check(16'(ring_irq), 16'h0001);
      rd_chk(8'h03, 8'h09);
      rd_chk(8'h03, 8'h00);
      check(16'(ring_irq), 16'h0000);
    end
    // silence after ringing: monitor drops, flag stays latched
    sense(7'h7F);
    sense(7'h01);
    rd_chk(8'h03, 8'h01);
    // masking by the enable alone
    wr_reg(8'h05, 8'h00);
    sense(7'h7F);
    @(negedge mclk);
    check(16'(ring_irq), 16'h0000);
    rd_chk(8'h05, 8'h00);
    wr_reg(8'h05, 8'h01);
    @(negedge mclk);
    check(16'(ring_irq), 16'h0001);
    rd_chk(8'h03, 8'h09);
    // unmapped place: write ignored, read zero
    wr_reg(8'h20, 8'hFF);
    rd_chk(8'h20, 8'h00);
    // caller id mode: receive path cut, sense path boosted
    wr_reg(8'h15, 8'hFF);
    rd_chk(8'h15, 8'h10);
    check(16'(cid_active), 16'h0001);
    rx_put(16'h1111);
    check(16'(ring_sense_ready), 16'h0001);
    repeat (4) @(negedge mclk);
    check(16'(sink.got.size()), 16'h0000);
    sense(7'h03);
    expect_word(16'hE200);
    sense(7'h14);
    expect_word(16'h8000);
    // caller id words back up against a stalled drain
    stall = 1'b1;
    for (i = 0; i < 8; i++) sense(7'h01);
    check(16'(ring_sense_ready), 16'h0000);
    stall = 1'b0;
    for (i = 0; i < 8; i++) expect_word(16'hF600);
    wr_reg(8'h14, 8'h08);
    sense(7'h01);
    expect_word(16'h9C00);
    rd_chk(8'h14, 8'h00);
    wr_reg(8'h15, 8'h00);
    // normal path with the receive boost still on, then off again
    rx_put(16'h0100);
    expect_word(16'h0A00);
    rx_put(16'h1000);
    expect_word(16'h7FFF);
    wr_reg(8'h14, 8'h00);
    check(16'(cid_active), 16'h0000);
    rx_put(16'h0100);
    expect_word(16'h0100);
    // normal path: fill the fifo against a stalled drain, then empty it
    stall = 1'b1;
    @(negedge mclk);
    for (i = 0; i < 9; i++) begin
      @(negedge mclk);
      rx_valid = 1'b1;
      rx_sample = 16'h0A00 + 16'(i);
      #1 check(16'(rx_ready), 16'(i < 8));
    end
    @(negedge mclk);
    rx_valid = 1'b0;
    check(16'(ring_sense_ready), 16'h0001);
    stall = 1'b0;
    for (i = 0; i < 8; i++) expect_word(16'h0A00 + 16'(i));
    repeat (3) @(negedge mclk);
    check(16'({pcm_valid, 15'(sink.got.size())}), 16'h0000);
    // mid-run reset brings every control back to its default
    wr_reg(8'h05, 8'h00);
    wr_reg(8'h0E, 8'h02);
    wr_reg(8'h14, 8'h08);
    wr_reg(8'h15, 8'h10);
    @(negedge mclk);
    rstn = 1'b0;
    repeat (2) @(negedge mclk);
    rstn = 1'b1;
    rd_chk(8'h05, 8'h01);
    rd_chk(8'h0E, 8'h00);
    check(16'({ring_irq, cid_active}), 16'h0000);
    rx_put(16'h0100);
    expect_word(16'h0100);
    conclude();
  end
endmodule : test_ring_detect_and_cid_control
